/* File: logic/icp_ctrl_port.sv */
// Two-wire slave control port: bit engine, address counter and register store
`timescale 1ns/1ps
`include "icp_regs.svh"

module icp_ctrl_port (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bus pins
   input wire logic sclPin,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // Strap and power pins
   input wire logic addressSelectPin,
   input wire logic powerDownPinN,
   // Register contents and status
   output logic [`ICP_REG_COUNT*8-1:0] ctrlRegs,
   output logic busActive,
   output logic sclTooFast
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and local reset

   logic [`ICP_PIN_COUNT-1:0] pinLevel;
   logic sclF;
   logic sdaF;
   logic adselF;
   logic pdnF;
   logic clear;

   icp_pin_sync #(
      .W(`ICP_PIN_COUNT),
      .RST_VAL(`ICP_PIN_RST)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .pinRaw({powerDownPinN, addressSelectPin, sdaIn, sclPin}),
      .pinLevel(pinLevel)
   );

   assign sclF = pinLevel[`ICP_PIN_SCL];
   assign sdaF = pinLevel[`ICP_PIN_SDA];
   assign adselF = pinLevel[`ICP_PIN_ADSEL];
   assign pdnF = pinLevel[`ICP_PIN_PDN];

   // Engine and registers are held cleared while the power-down pin is low
   assign clear = srst | ~pdnF;

   ////////////////////////////////////////////////////////////////////////////
   // Register store

   icp_reg_if regBus ();

   icp_reg_file u_regs (
      .clk(clk),
      .clear(clear),
      .bus(regBus),
      .regsOut(ctrlRegs)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Engine state

   icp_pkg::icp_ctrl_s s_r;
   icp_pkg::icp_ctrl_s s_nxt;

   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic addrMatch;
   logic byteDone;
   logic lastTxBit;

   assign sclRise = sclF & ~s_r.sclPrev;
   assign sclFall = ~sclF & s_r.sclPrev;
   assign startSeen = sclF & s_r.sclPrev & s_r.sdaPrev & ~sdaF;
   assign stopSeen = sclF & s_r.sclPrev & ~s_r.sdaPrev & sdaF;
   assign addrMatch = (s_r.shift[7:1] == {`ICP_DEV_ADDR_HI, adselF});

   // Eighth falling edge closes a received byte
   assign byteDone = sclFall && (s_r.bitCnt == `ICP_BYTE_BITS);
   assign lastTxBit = (s_r.bitCnt == `ICP_LAST_BIT);

   // Address counter step; the two-bit width gives the wrap from 3 to 0
   function automatic logic [1:0] nextAddr(input logic [1:0] a);
      return a + 2'h1;
   endfunction : nextAddr

   // Open drain: a zero bit is sent by pulling the line low
   function automatic logic pullFor(input logic b);
      return ~b;
   endfunction : pullFor

   // Writes carry their own address; otherwise the counter selects the read
   assign regBus.wrEn = s_r.wrEn;
   assign regBus.addr = s_r.wrEn ? s_r.wrAddr : s_r.addrCnt;
   assign regBus.wrData = s_r.wrData;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      s_nxt = s_r;
      s_nxt.wrEn = 1'b0;
      s_nxt.sclPrev = sclF;
      s_nxt.sdaPrev = sdaF;

      // Clock high time below fast-mode minimum flags an over-speed bus
      if (sclF) begin
         if (s_r.highCnt != 7'h7f) begin
            s_nxt.highCnt = s_r.highCnt + 7'h01;
         end
      end else begin
         s_nxt.highCnt = 7'h00;
      end
      if (sclFall && (s_r.highCnt < 7'(`ICP_SCL_HIGH_MIN_CYC))) begin
         s_nxt.fastScl = 1'b1;
      end else if (startSeen) begin
         s_nxt.fastScl = 1'b0;
      end

      // Pin drive follows the wanted level only after the hold time
      if (s_r.holdCnt != 7'h00) begin
         s_nxt.holdCnt = s_r.holdCnt - 7'h01;
      end else begin
         s_nxt.sdaOe = s_r.sdaLow;
      end

      if (startSeen) begin
         s_nxt.state = icp_pkg::ST_ADDR;
         s_nxt.bitCnt = 4'h0;
         s_nxt.sdaLow = 1'b0;
      end else if (stopSeen) begin
         s_nxt.state = icp_pkg::ST_IDLE;
         s_nxt.sdaLow = 1'b0;
      end else begin
         case (s_r.state)
            // Receive phases: address, register address, write data
            icp_pkg::ST_ADDR,
            icp_pkg::ST_REG,
            icp_pkg::ST_WDATA: begin
               if (sclRise) begin
                  s_nxt.shift = {s_r.shift[6:0], sdaF};
                  s_nxt.bitCnt = s_r.bitCnt + 4'h1;
               end else if (byteDone) begin
                  s_nxt.bitCnt = 4'h0;
                  if (s_r.state == icp_pkg::ST_ADDR) begin
                     if (addrMatch) begin
                        s_nxt.rw = s_r.shift[0];
                        s_nxt.sdaLow = 1'b1;
                        s_nxt.state = icp_pkg::ST_ACK_ADDR;
                     end else begin
                        s_nxt.state = icp_pkg::ST_WAIT_STOP;
                     end
                  end else if (s_r.state == icp_pkg::ST_REG) begin
                     s_nxt.addrCnt = s_r.shift[1:0];
                     s_nxt.sdaLow = 1'b1;
                     s_nxt.state = icp_pkg::ST_ACK_REG;
                  end else begin
                     s_nxt.wrEn = 1'b1;
                     s_nxt.wrAddr = s_r.addrCnt;
                     s_nxt.wrData = s_r.shift;
                     s_nxt.addrCnt = nextAddr(s_r.addrCnt);
                     s_nxt.sdaLow = 1'b1;
                     s_nxt.state = icp_pkg::ST_ACK_WDATA;
                  end
               end
            end
            // Acknowledge of the address byte turns the bus round for reads
            icp_pkg::ST_ACK_ADDR: begin
               if (sclFall) begin
                  if (s_r.rw == `ICP_RW_READ) begin
                     s_nxt.shift = regBus.rdData;
                     s_nxt.sdaLow = pullFor(regBus.rdData[7]);
                     s_nxt.addrCnt = nextAddr(s_r.addrCnt);
                     s_nxt.state = icp_pkg::ST_RDATA;
                  end else begin
                     s_nxt.sdaLow = 1'b0;
                     s_nxt.state = icp_pkg::ST_REG;
                  end
               end
            end
            icp_pkg::ST_ACK_REG,
            icp_pkg::ST_ACK_WDATA: begin
               if (sclFall) begin
                  s_nxt.sdaLow = 1'b0;
                  s_nxt.state = icp_pkg::ST_WDATA;
               end
            end
            // Transmit phases: data bits, then the master's acknowledge
            icp_pkg::ST_RDATA: begin
               if (sclFall) begin
                  if (lastTxBit) begin
                     s_nxt.bitCnt = 4'h0;
                     s_nxt.sdaLow = 1'b0;
                     s_nxt.state = icp_pkg::ST_RACK;
                  end else begin
                     s_nxt.shift = {s_r.shift[6:0], 1'b0};
                     s_nxt.sdaLow = pullFor(s_r.shift[6]);
                     s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                  end
               end
            end
            // A released line at the ninth rise is a no-acknowledge
            icp_pkg::ST_RACK: begin
               if (sclRise) begin
                  s_nxt.ackSeen = ~sdaF;
               end else if (sclFall) begin
                  if (s_r.ackSeen) begin
                     s_nxt.shift = regBus.rdData;
                     s_nxt.sdaLow = pullFor(regBus.rdData[7]);
                     s_nxt.addrCnt = nextAddr(s_r.addrCnt);
                     s_nxt.state = icp_pkg::ST_RDATA;
                  end else begin
                     s_nxt.state = icp_pkg::ST_WAIT_STOP;
                  end
               end
            end
            // Bus ignored until the next start or stop
            icp_pkg::ST_WAIT_STOP: begin
               s_nxt.sdaLow = 1'b0;
            end
            default: begin
               s_nxt.sdaLow = 1'b0;
            end
         endcase
      end

      // Every drive change waits out the hold time after the clock falls
      if (sclFall) begin
         s_nxt.holdCnt = 7'(`ICP_HOLD_CYC);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk) begin
      if (clear) begin
         s_r.state <= icp_pkg::ST_IDLE;
         s_r.shift <= 8'h00;
         s_r.bitCnt <= 4'h0;
         s_r.rw <= 1'b0;
         s_r.addrCnt <= `ICP_ADDR_FIRST;
         s_r.ackSeen <= 1'b0;
         s_r.sdaLow <= 1'b0;
         s_r.sdaOe <= 1'b0;
         s_r.holdCnt <= 7'h00;
         s_r.highCnt <= 7'h00;
         s_r.sclPrev <= 1'b1;
         s_r.sdaPrev <= 1'b1;
         s_r.wrEn <= 1'b0;
         s_r.wrAddr <= `ICP_ADDR_FIRST;
         s_r.wrData <= 8'h00;
         s_r.fastScl <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Open drain: the pin is only ever pulled low
   assign sdaOut = 1'b0;
   assign sdaOe = s_r.sdaOe;
   assign busActive = (s_r.state != icp_pkg::ST_IDLE);
   assign sclTooFast = s_r.fastScl;

endmodule : icp_ctrl_port

/* File: logic/icp_regs.svh */
// Constants of the two-wire control port: addresses, defaults, masks, timing
`ifndef ICP_REGS_SVH
`define ICP_REGS_SVH

// Register file shape
`define ICP_REG_COUNT 4
`define ICP_ADDR_W 2
`define ICP_REG0_IDX 2'h0
`define ICP_REG1_IDX 2'h1
`define ICP_REG2_IDX 2'h2
`define ICP_REG3_IDX 2'h3
`define ICP_ADDR_FIRST 2'h0

// Defaults after reset or power-down
`define ICP_REG0_RST 8'h01
`define ICP_REG1_RST 8'h55
`define ICP_REG2_RST 8'h00
`define ICP_REG3_RST 8'h00

// Writable bits; the others keep their fixed default
`define ICP_REG0_MASK 8'h75
`define ICP_REG1_MASK 8'h3f
`define ICP_REG2_MASK 8'h77
`define ICP_REG3_MASK 8'h07

// Slave address: fixed upper six bits, seventh bit from the select pin
`define ICP_DEV_ADDR_HI 6'h09
`define ICP_RW_READ 1'h1

// Byte framing
`define ICP_LAST_BIT 4'h7
`define ICP_BYTE_BITS 4'h8

// Pin positions in the synchroniser vector
`define ICP_PIN_SCL 0
`define ICP_PIN_SDA 1
`define ICP_PIN_ADSEL 2
`define ICP_PIN_PDN 3
`define ICP_PIN_COUNT 4
`define ICP_PIN_RST 4'h3

// Timing
`define ICP_CLK_NS 8
`define ICP_SCL_MAX_KHZ 400
`define ICP_SCL_HIGH_MIN_NS 600
`define ICP_HOLD_NS 300
`define ICP_HOLD_CYC ((`ICP_HOLD_NS + `ICP_CLK_NS - 1) / `ICP_CLK_NS)
`define ICP_SCL_HIGH_MIN_CYC (`ICP_SCL_HIGH_MIN_NS / `ICP_CLK_NS)
`define ICP_CNT_W 7

`endif

/* File: logic/icp_pkg.sv */
// Types shared by the two-wire control port modules
package icp_pkg;

   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_ADDR = 10'h002,
      ST_ACK_ADDR = 10'h004,
      ST_REG = 10'h008,
      ST_ACK_REG = 10'h010,
      ST_WDATA = 10'h020,
      ST_ACK_WDATA = 10'h040,
      ST_RDATA = 10'h080,
      ST_RACK = 10'h100,
      ST_WAIT_STOP = 10'h200
   } icp_state_e;

   typedef struct packed {
      icp_state_e state;
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic rw;
      logic [1:0] addrCnt;
      logic ackSeen;
      logic sdaLow;
      logic sdaOe;
      logic [6:0] holdCnt;
      logic [6:0] highCnt;
      logic sclPrev;
      logic sdaPrev;
      logic wrEn;
      logic [1:0] wrAddr;
      logic [7:0] wrData;
      logic fastScl;
   } icp_ctrl_s;

endpackage : icp_pkg

/* File: logic/icp_reg_if.sv */
// Register access channel between the bus engine and the register store
`timescale 1ns/1ps
interface icp_reg_if;
   logic wrEn;
   logic [1:0] addr;
   logic [7:0] wrData;
   logic [7:0] rdData;

   modport engine (output wrEn, output addr, output wrData, input rdData);
   modport store (input wrEn, input addr, input wrData, output rdData);
endinterface : icp_reg_if

/* File: logic/icp_pin_sync.sv */
// Three-stage pin synchroniser that accepts a level once stages two and three agree
`timescale 1ns/1ps
`include "icp_regs.svh"
module icp_pin_sync #(
   parameter int W = `ICP_PIN_COUNT,
   parameter logic [W-1:0] RST_VAL = `ICP_PIN_RST
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Pins and filtered levels
   input wire logic [W-1:0] pinRaw,
   output logic [W-1:0] pinLevel
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
   } icp_sync_s;

   icp_sync_s s_r;
   icp_sync_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = pinRaw;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      for (int i = 0; i < W; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.level[i] = s_r.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pinLevel = s_r.level;

endmodule : icp_pin_sync

/* File: logic/icp_reg_file.sv */
// Four control registers with fixed bits, defaults and registered read data
`timescale 1ns/1ps
`include "icp_regs.svh"
module icp_reg_file (
   // Clock and clear
   input wire logic clk,
   input wire logic clear,
   // Access channel
   icp_reg_if.store bus,
   // Register contents
   output logic [`ICP_REG_COUNT*8-1:0] regsOut
);

   typedef struct packed {
      logic [`ICP_REG_COUNT-1:0][7:0] regs;
      logic [7:0] rd;
   } icp_store_s;

   icp_store_s s_r;
   icp_store_s s_nxt;

   function automatic logic [7:0] rstVal(input logic [1:0] idx);
      if (idx == `ICP_REG0_IDX) begin
         return `ICP_REG0_RST;
      end else if (idx == `ICP_REG1_IDX) begin
         return `ICP_REG1_RST;
      end else if (idx == `ICP_REG2_IDX) begin
         return `ICP_REG2_RST;
      end else begin
         return `ICP_REG3_RST;
      end
   endfunction : rstVal

   function automatic logic [7:0] wrMask(input logic [1:0] idx);
      if (idx == `ICP_REG0_IDX) begin
         return `ICP_REG0_MASK;
      end else if (idx == `ICP_REG1_IDX) begin
         return `ICP_REG1_MASK;
      end else if (idx == `ICP_REG2_IDX) begin
         return `ICP_REG2_MASK;
      end else begin
         return `ICP_REG3_MASK;
      end
   endfunction : wrMask

   always_comb begin
      s_nxt = s_r;
      if (bus.wrEn) begin
         s_nxt.regs[bus.addr] = (bus.wrData & wrMask(bus.addr)) |
            (rstVal(bus.addr) & ~wrMask(bus.addr));
      end
      s_nxt.rd = s_r.regs[bus.addr];
   end

   always_ff @(posedge clk) begin
      if (clear) begin
         for (int i = 0; i < `ICP_REG_COUNT; i++) begin
            s_r.regs[i] <= rstVal(2'(i));
         end
         s_r.rd <= `ICP_REG0_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.rdData = s_r.rd;
   assign regsOut = s_r.regs;

endmodule : icp_reg_file

/* File: verification/icp_ctrl_port_sva.sv */
// Checker of the control port pins: framing, acknowledge, drive timing
`timescale 1ns/1ps
`include "icp_regs.svh"
module icp_ctrl_port_sva (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Bus pins
   input wire logic sclPin,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // Strap and power pins
   input wire logic addressSelectPin,
   input wire logic powerDownPinN,
   // Register contents and status
   input wire logic [`ICP_REG_COUNT*8-1:0] ctrlRegs,
   input wire logic busActive,
   input wire logic sclTooFast
);
   localparam logic [31:0] DEF = {`ICP_REG3_RST, `ICP_REG2_RST,
                                  `ICP_REG1_RST, `ICP_REG0_RST};
   logic sclQ, sdaQ, first, hit, rd, nak;
   logic [3:0] cnt;
   logic [7:0] sh, lowCnt;
   wire logic rise = sclPin && !sclQ;
   wire logic strt = sclPin && sclQ && sdaQ && !sdaIn;
   wire logic stp = sclPin && sclQ && !sdaQ && sdaIn;
   wire logic rise9 = rise && cnt == 4'h8;
   wire logic match = sh[7:1] == {6'h09, addressSelectPin};
   ////////////////////////////////////////////////////////////////////////////
   // Bit-level monitor of the raw pins
   always_ff @(posedge clk) begin
      sclQ <= sclPin;
      sdaQ <= sdaIn;
      lowCnt <= (sclPin || lowCnt == 8'hff) ? {8{!sclPin}} & lowCnt
                                            : lowCnt + 8'h01;
      if (srst || strt || stp) begin
         cnt <= 4'h0;
         first <= strt;
         hit <= 1'b0;
         rd <= 1'b0;
         nak <= 1'b0;
      end else if (rise9) begin
         cnt <= 4'h0;
         first <= 1'b0;
         hit <= first ? match : hit;
         rd <= first ? sh[0] : rd;
         nak <= nak || (!first && rd && sdaIn);
      end else if (rise) begin
         cnt <= cnt + 4'h1;
         sh <= {sh[6:0], sdaIn};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   AST_OPEN_DRAIN: assert property (sdaOe |-> sdaOut == 1'b0)
      else $error("data pin driven high");
   AST_STABLE_HIGH: assert property (sclPin && $past(sclPin)
      |-> $stable(sdaOe)) else $error("data moved while clock high");
   AST_HOLD: assert property ($changed(sdaOe) |-> lowCnt >= 8'd38)
      else $error("data moved too soon after clock fall");
   AST_START_BUSY: assert property (strt |-> ##[1:8] busActive)
      else $error("start not taken");
   AST_STOP_IDLE: assert property (stp |-> ##[1:8] !busActive)
      else $error("stop not taken");
   AST_ADDR_ACK: assert property (rise9 && first && match |-> sdaOe)
      else $error("own address not acknowledged");
   AST_DATA_ACK: assert property (rise9 && !first && hit && !rd
      |-> sdaOe) else $error("written byte not acknowledged");
   AST_RD_RELEASE: assert property (rise9 && !first && hit && rd
      |-> !sdaOe) else $error("acknowledge slot not released");
   AST_SILENT: assert property ((!first && !hit) || nak
      |-> !sdaOe) else $error("data driven while not addressed");
   AST_PDN_DEFAULTS: assert property (!powerDownPinN [*6]
      |-> ctrlRegs == DEF) else $error("defaults not restored");
   cover property (rise9 && first && match);
   cover property (rise9 && first && !match);
   cover property (rise9 && !first && hit && !rd);
   cover property (rise9 && rd && sdaIn && hit);
   cover property ($rose(sclTooFast));
endmodule : icp_ctrl_port_sva

bind icp_ctrl_port icp_ctrl_port_sva chk (.clk(clk), .srst(srst),
   .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .addressSelectPin(addressSelectPin), .powerDownPinN(powerDownPinN),
   .ctrlRegs(ctrlRegs), .busActive(busActive), .sclTooFast(sclTooFast));

/* File: verification/icp_bus_master.sv */
// Bus master model: drives the clock, pulls data low, samples the line
`timescale 1ns/1ps
module icp_bus_master (
   // Clock
   input wire logic clk,
   // Bus
   output logic sclPin,
   output logic sdaPullLow,
   input wire logic sdaLine
);
   // Quarter bit, keeps the bit rate just under 400 kHz
   localparam int QTR = 79;
   initial begin
      sclPin = 1'b1;
      sdaPullLow = 1'b0;
   end
   task automatic qtr();
      repeat (QTR) @(posedge clk);
      #1;
   endtask : qtr
   // Data set mid-low, sampled mid-high
   task automatic bit_io(input logic b, output logic s);
      qtr();
      sdaPullLow = !b;
      qtr();
      sclPin = 1'b1;
      qtr();
      s = sdaLine;
      qtr();
      sclPin = 1'b0;
   endtask : bit_io
   task automatic start();
      qtr();
      sdaPullLow = 1'b0;
      qtr();
      sclPin = 1'b1;
      qtr();
      sdaPullLow = 1'b1;
      qtr();
      sclPin = 1'b0;
   endtask : start
   task automatic stop();
      qtr();
      sdaPullLow = 1'b1;
      qtr();
      sclPin = 1'b1;
      qtr();
      sdaPullLow = 1'b0;
      qtr();
   endtask : stop
   // Clock pulse far shorter than the fast-mode high minimum
   task automatic fast_pulse();
      qtr();
      sclPin = 1'b0;
      repeat (40) @(posedge clk);
      #1;
      sclPin = 1'b1;
      repeat (40) @(posedge clk);
      #1;
      sclPin = 1'b0;
      qtr();
      sclPin = 1'b1;
   endtask : fast_pulse
   task automatic xfer(input logic [7:0] tx, input logic ackOut,
                       output logic [7:0] rx, output logic ackIn);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(!ackOut, s);
      ackIn = !s;
   endtask : xfer
endmodule : icp_bus_master

/* File: verification/tb_top.sv */
// Testbench of the control port: writes, reads, foreign address, power-down
`timescale 1ns/1ps
`include "icp_regs.svh"
module tb_top;
   localparam logic [7:0] MSK [4] = '{`ICP_REG0_MASK, `ICP_REG1_MASK,
                                      `ICP_REG2_MASK, `ICP_REG3_MASK};
   localparam logic [7:0] DEF [4] = '{`ICP_REG0_RST, `ICP_REG1_RST,
                                      `ICP_REG2_RST, `ICP_REG3_RST};
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic addressSelectPin = 1'b1;
   logic powerDownPinN = 1'b1;
   logic sclPin, mstLow, sdaOut, sdaOe, busActive, sclTooFast, ack;
   logic [31:0] ctrlRegs;
   logic [7:0] mdl [4];
   logic [7:0] rx;
   int miscompares = 0;
   int nCompared = 0;
   wire logic sdaLine = !(mstLow || (sdaOe && !sdaOut));
   always #4 clk = ~clk;
   icp_ctrl_port dut (.clk(clk), .srst(srst), .sclPin(sclPin),
      .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .addressSelectPin(addressSelectPin), .powerDownPinN(powerDownPinN),
      .ctrlRegs(ctrlRegs), .busActive(busActive), .sclTooFast(sclTooFast));
   icp_bus_master mst (.clk(clk), .sclPin(sclPin), .sdaPullLow(mstLow),
      .sdaLine(sdaLine));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk_bit(input string nm, input logic e, input logic g);
      nCompared++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit
   task automatic chk_vec(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
      nCompared++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk_vec
   function automatic logic [7:0] addr(input logic rw);
      return {6'h09, addressSelectPin, rw};
   endfunction : addr
   function automatic void store(input int i, input logic [7:0] d);
      mdl[i] = (d & MSK[i]) | (DEF[i] & ~MSK[i]);
   endfunction : store
   task automatic put(input logic [7:0] b);
      mst.xfer(b, 1'b0, rx, ack);
      chk_bit("ack", 1'b1, ack);
   endtask : put
   task automatic get(input int i, input logic more);
      mst.xfer(8'hff, more, rx, ack);
      chk_vec("read byte", {24'h0, mdl[i]}, {24'h0, rx});
   endtask : get
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_write_wrap();
      mst.start();
      chk_bit("busy", 1'b1, busActive);
      put(addr(1'b0));
      put(8'h02);
      put(8'h5a);
      put(8'hff);
      put(8'h00);
      put(8'hab);
      mst.stop();
      repeat (10) @(posedge clk);
      store(2, 8'h5a);
      store(3, 8'hff);
      store(0, 8'h00);
      store(1, 8'hab);
      chk_vec("regs", {mdl[3], mdl[2], mdl[1], mdl[0]}, ctrlRegs);
      chk_bit("busy", 1'b0, busActive);
   endtask : t_write_wrap
   task automatic t_read_current();
      mst.start();
      put(addr(1'b1));
      get(2, 1'b1);
      get(3, 1'b1);
      get(0, 1'b1);
      get(1, 1'b0);
      mst.stop();
   endtask : t_read_current
   task automatic t_random_read();
      mst.start();
      put(addr(1'b0));
      put(8'h01);
      mst.start();
      put(addr(1'b1));
      get(1, 1'b0);
      mst.stop();
   endtask : t_random_read
   task automatic t_foreign();
      for (int i = 0; i < 2; i++) begin
         mst.start();
         mst.xfer(i ? {6'h29, 2'h2} : {6'h09, 2'h0}, 1'b0, rx, ack);
         chk_bit("ack", 1'b0, ack);
         mst.xfer(8'h00, 1'b0, rx, ack);
         chk_bit("ack", 1'b0, ack);
         mst.stop();
      end
      mst.start();
      put(addr(1'b1));
      get(2, 1'b0);
      mst.stop();
   endtask : t_foreign
   task automatic t_power_down();
      powerDownPinN = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++) begin
         mdl[i] = DEF[i];
      end
      chk_vec("regs", {mdl[3], mdl[2], mdl[1], mdl[0]}, ctrlRegs);
      powerDownPinN = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      mst.start();
      put(addr(1'b1));
      get(0, 1'b0);
      mst.stop();
   endtask : t_power_down
   task automatic t_fast_clock();
      mst.fast_pulse();
      repeat (10) @(posedge clk);
      #1;
      chk_bit("too fast", 1'b1, sclTooFast);
      mst.start();
      chk_bit("too fast", 1'b0, sclTooFast);
      mst.stop();
   endtask : t_fast_clock
   task automatic report_and_stop();
      $display("compared %0d, miscompares %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      #1 srst = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++) begin
         mdl[i] = DEF[i];
      end
      chk_vec("regs", {mdl[3], mdl[2], mdl[1], mdl[0]}, ctrlRegs);
      t_write_wrap();
      t_read_current();
      t_random_read();
      t_foreign();
      t_power_down();
      chk_bit("too fast", 1'b0, sclTooFast);
      t_fast_clock();
      report_and_stop();
   end
   // Whole run needs about 71000 cycles
   initial begin
      repeat (95000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
endmodule : tb_top
